// file: p0pm_pkg.sv
// constants for the port 0 pin mux and direction block
// assumes an 8-bit special-function-register space and one cpu clock
// Function
// RULE1: reset makes every port 0 pin input
// RULE2: reset sets port 1 serial-master directions
// RULE3: reset configuration holds until software writes
// RULE4: function select outranks direction per pin
// RULE5: uart receive pin still follows direction bit
// RULE6: select clear gives gpio with direction bit
// RULE7: fixed alternate function and direction per bit
// RULE8: software must select irq pins to interrupt
// RULE9: timer inputs sampled every four clocks
// RULE10: direction 0 output, 1 input, resets ones
// RULE11: registers at 0x80, 0x93, 0x94, 0x95
// RULE12: strong drive bit enables high drive
// RULE13: every pin bidirectional, per-bit direction control
// RULE14: odd bits source, even bits sink current
// RULE15: port 1 serial master only in mode 01
// RULE16: data read gives pins or output latch
// RULE17: external pins pass two-flop synchroniser
package p0pm_pkg;
    localparam logic [7:0] ADDR_DATA = 8'h80;
    localparam logic [7:0] ADDR_DRIVE = 8'h93;
    localparam logic [7:0] ADDR_DIR = 8'h94;
    localparam logic [7:0] ADDR_ALT = 8'h95;
    localparam logic [7:0] RST_DATA = 8'hFF;
    localparam logic [7:0] RST_DRIVE = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_ALT = 8'h00;
    localparam logic [7:0] RST_READ = 8'h00;
    // bits whose alternate function always drives the pin
    localparam logic [7:0] ALT_OUT_MASK = 8'h85;
    localparam int BIT_GENERAL_TIMER_OUTPUT = 0;
    localparam int BIT_RXD = 1;
    localparam int BIT_TXD = 2;
    localparam int BIT_IRQ0 = 3;
    localparam int BIT_IRQ1 = 4;
    localparam int BIT_T0 = 5;
    localparam int BIT_T1 = 6;
    localparam int BIT_PWM = 7;
    localparam logic [7:0] SOURCE_MASK = 8'hAA;
    localparam logic [7:0] SINK_MASK = 8'h55;
    localparam int TSAMPLE_CYCLES = 4;
    localparam logic [1:0] TSAMPLE_LAST = 2'(TSAMPLE_CYCLES - 1);
    localparam logic [1:0] SPI_MASTER_MODE = 2'h1;
    // port 1: sck, mosi, miso, select; miso is always an input
    localparam logic [3:0] P1_MASTER_OE = 4'hB;
    localparam logic [3:0] P1_GPIO_MASK = 4'hB;
endpackage : p0pm_pkg

// file: p0pm_sync_if.sv
// carrier between the port block and its pin synchroniser
// assumes both ends run on the cpu clock
`timescale 1ns/100ps
interface p0pm_sync_if;
    logic [7:0] raw;
    logic [7:0] synced;
    logic [1:0] timer_level;
    logic timer_tick;
    modport port_side (output raw, input synced, input timer_level, input timer_tick);
    modport sync_side (input raw, output synced, output timer_level, output timer_tick);
endinterface : p0pm_sync_if

// file: p0pm_sync.sv
// two-flop synchroniser for port 0 pins plus timer input sampler
// assumes raw pin levels are asynchronous to sys_clk_in
`timescale 1ns/100ps
module p0pm_sync (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // pins towards the port block
    p0pm_sync_if.sync_side pins
);
    logic [7:0] meta;
    logic [7:0] stable;
    logic [1:0] phase;
    logic [1:0] tlevel;
    logic tick;
    logic [1:0] next_phase;
    logic [1:0] next_tlevel;
    logic next_tick;

    always_comb begin
        next_phase = (phase == p0pm_pkg::TSAMPLE_LAST) ? 2'h0 : phase + 2'h1;
        next_tick = (phase == p0pm_pkg::TSAMPLE_LAST);
        next_tlevel = tlevel;
        if (phase == p0pm_pkg::TSAMPLE_LAST) begin
            next_tlevel = {stable[p0pm_pkg::BIT_T1], stable[p0pm_pkg::BIT_T0]}; // RULE9
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            meta <= 8'hFF;
            stable <= 8'hFF;
            phase <= 2'h0;
            tlevel <= 2'h0;
            tick <= 1'b0;
        end else begin
            meta <= pins.raw; // RULE17
            stable <= meta; // RULE17
            phase <= next_phase;
            tlevel <= next_tlevel;
            tick <= next_tick;
        end
    end

    assign pins.synced = stable;
    assign pins.timer_level = tlevel;
    assign pins.timer_tick = tick;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    a_sync_two_stages: assert property (!$past(rst_in, 2) |-> stable == $past(pins.raw, 2)) // RULE17
        else $error("synchronised pin does not lag raw pin by two clocks");
    a_timer_tick_spacing: assert property (tick |=> !tick [*3] ##1 tick) // RULE9
        else $error("timer sample tick not every four clocks");
    a_timer_level_hold: assert property (!tick |-> $stable(tlevel)) // RULE9
        else $error("timer level changed between samples");
    c_timer_sample: cover property (tick ##4 tick);
endmodule : p0pm_sync

// file: p0pm_port.sv
// port 0 pin mux, direction and drive logic with its sfr registers,
// plus port 1 direction select for serial-master mode
// assumes an sfr port on the cpu clock and pins as in/out/oe triples
`timescale 1ns/100ps
module p0pm_port (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // sfr access
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    output logic [7:0] sfr_rdata_out,
    // port 0 pins
    input wire logic [7:0] p0_pin_in,
    output logic [7:0] p0_pin_out,
    output logic [7:0] p0_pin_oe_out,
    output logic [7:0] p0_hi_source_out,
    output logic [7:0] p0_hi_sink_out,
    // alternate function sources
    input wire logic general_timer_output_in,
    input wire logic uart_rxd_drive_in,
    input wire logic uart_txd_in,
    input wire logic pwm_in,
    // alternate function destinations
    output logic uart_rxd_out,
    output logic ext_irq0_n_out,
    output logic ext_irq1_n_out,
    output logic timer0_input_out,
    output logic timer1_input_out,
    // port 1 direction
    input wire logic [1:0] serial_port_mode_in,
    input wire logic [3:0] p1_direction_in,
    output logic [3:0] p1_pin_oe_out
);
    logic [7:0] data_latch;
    logic [7:0] drive_en;
    logic [7:0] direction;
    logic [7:0] alt_sel;
    logic [7:0] next_data_latch;
    logic [7:0] next_drive_en;
    logic [7:0] next_direction;
    logic [7:0] next_alt_sel;
    logic [7:0] next_rdata;
    logic [7:0] next_pin_out;
    logic [7:0] next_pin_oe;
    logic [7:0] next_hi_source;
    logic [7:0] next_hi_sink;
    logic [7:0] alt_value;
    logic [7:0] alt_oe;
    logic [3:0] next_p1_oe;
    logic next_rxd;
    logic next_irq0_n;
    logic next_irq1_n;
    logic next_t0;
    logic next_t1;
    logic wr_data;
    logic wr_drive;
    logic wr_dir;
    logic wr_alt;

    p0pm_sync_if sif ();

    p0pm_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .pins(sif.sync_side)
    );

    assign sif.raw = p0_pin_in;

    // register writes
    always_comb begin
        wr_data = sfr_wr_in && (sfr_addr_in == p0pm_pkg::ADDR_DATA); // RULE11
        wr_drive = sfr_wr_in && (sfr_addr_in == p0pm_pkg::ADDR_DRIVE); // RULE11
        wr_dir = sfr_wr_in && (sfr_addr_in == p0pm_pkg::ADDR_DIR); // RULE11
        wr_alt = sfr_wr_in && (sfr_addr_in == p0pm_pkg::ADDR_ALT); // RULE11
        // configuration only moves on an explicit write
        next_data_latch = wr_data ? sfr_wdata_in : data_latch;
        next_drive_en = wr_drive ? sfr_wdata_in : drive_en;
        next_direction = wr_dir ? sfr_wdata_in : direction; // RULE3
        next_alt_sel = wr_alt ? sfr_wdata_in : alt_sel; // RULE3
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            data_latch <= p0pm_pkg::RST_DATA;
            drive_en <= p0pm_pkg::RST_DRIVE;
            direction <= p0pm_pkg::RST_DIR; // RULE10
            alt_sel <= p0pm_pkg::RST_ALT;
        end else begin
            data_latch <= next_data_latch;
            drive_en <= next_drive_en;
            direction <= next_direction;
            alt_sel <= next_alt_sel;
        end
    end

    // register reads, answered one clock after the strobe
    always_comb begin
        next_rdata = p0pm_pkg::RST_READ;
        if (sfr_rd_in) begin
            unique case (sfr_addr_in)
                // output pins read back the latch, inputs the synchronised pin
                p0pm_pkg::ADDR_DATA: next_rdata = (sif.synced & ~p0_pin_oe_out) |
                    (data_latch & p0_pin_oe_out); // RULE16
                p0pm_pkg::ADDR_DRIVE: next_rdata = drive_en;
                p0pm_pkg::ADDR_DIR: next_rdata = direction;
                p0pm_pkg::ADDR_ALT: next_rdata = alt_sel;
                default: next_rdata = p0pm_pkg::RST_READ;
            endcase
        end
    end

    // pin mux
    always_comb begin
        alt_value = data_latch;
        alt_value[p0pm_pkg::BIT_GENERAL_TIMER_OUTPUT] = general_timer_output_in; // RULE7
        alt_value[p0pm_pkg::BIT_RXD] = uart_rxd_drive_in; // RULE7
        alt_value[p0pm_pkg::BIT_TXD] = uart_txd_in; // RULE7
        alt_value[p0pm_pkg::BIT_PWM] = pwm_in; // RULE7
        alt_oe = p0pm_pkg::ALT_OUT_MASK; // RULE7
        alt_oe[p0pm_pkg::BIT_RXD] = ~direction[p0pm_pkg::BIT_RXD]; // RULE5
        for (int i = 0; i < 8; i++) begin
            // select outranks direction; each pin steered on its own
            next_pin_oe[i] = alt_sel[i] ? alt_oe[i] : ~direction[i]; // RULE4 RULE6 RULE13
            next_pin_out[i] = alt_sel[i] ? alt_value[i] : data_latch[i]; // RULE4 RULE6
        end
        next_hi_source = drive_en & p0pm_pkg::SOURCE_MASK & next_pin_oe; // RULE12 RULE14
        next_hi_sink = drive_en & p0pm_pkg::SINK_MASK & next_pin_oe; // RULE12 RULE14
        // unselected peripheral inputs idle at their inactive level
        next_rxd = alt_sel[p0pm_pkg::BIT_RXD] ? sif.synced[p0pm_pkg::BIT_RXD] : 1'b1;
        next_irq0_n = alt_sel[p0pm_pkg::BIT_IRQ0] ? sif.synced[p0pm_pkg::BIT_IRQ0] : 1'b1; // RULE8
        next_irq1_n = alt_sel[p0pm_pkg::BIT_IRQ1] ? sif.synced[p0pm_pkg::BIT_IRQ1] : 1'b1; // RULE8
        next_t0 = alt_sel[p0pm_pkg::BIT_T0] & sif.timer_level[0]; // RULE9
        next_t1 = alt_sel[p0pm_pkg::BIT_T1] & sif.timer_level[1]; // RULE9
        // port 1 hardware direction only in serial-master mode
        next_p1_oe = (serial_port_mode_in == p0pm_pkg::SPI_MASTER_MODE) ?
            p0pm_pkg::P1_MASTER_OE : (~p1_direction_in & p0pm_pkg::P1_GPIO_MASK); // RULE15
    end

    // reset is synchronous, so pins float as inputs from the first clock edge in reset
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            sfr_rdata_out <= p0pm_pkg::RST_READ;
            p0_pin_out <= p0pm_pkg::RST_DATA;
            p0_pin_oe_out <= 8'h00; // RULE1
            p0_hi_source_out <= 8'h00;
            p0_hi_sink_out <= 8'h00;
            uart_rxd_out <= 1'b1;
            ext_irq0_n_out <= 1'b1;
            ext_irq1_n_out <= 1'b1;
            timer0_input_out <= 1'b0;
            timer1_input_out <= 1'b0;
            p1_pin_oe_out <= p0pm_pkg::P1_MASTER_OE; // RULE2
        end else begin
            sfr_rdata_out <= next_rdata;
            p0_pin_out <= next_pin_out;
            p0_pin_oe_out <= next_pin_oe;
            p0_hi_source_out <= next_hi_source;
            p0_hi_sink_out <= next_hi_sink;
            uart_rxd_out <= next_rxd;
            ext_irq0_n_out <= next_irq0_n;
            ext_irq1_n_out <= next_irq1_n;
            timer0_input_out <= next_t0;
            timer1_input_out <= next_t1;
            p1_pin_oe_out <= next_p1_oe;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking

    a_reset_all_inputs: assert property (rst_in |=> p0_pin_oe_out == 8'h00) // RULE1
        else $error("port 0 pin driven after reset clock");
    a_reset_p1_master: assert property (rst_in |=> p1_pin_oe_out == p0pm_pkg::P1_MASTER_OE) // RULE2
        else $error("port 1 not in serial-master direction during reset");
    a_config_holds: assert property (disable iff (rst_in)
        (!wr_dir && !wr_alt) |=> $stable(direction) && $stable(alt_sel)) // RULE3
        else $error("configuration changed without a write");
    a_alt_over_dir: assert property (disable iff (rst_in)
        alt_sel[0] && direction[0] |=> p0_pin_oe_out[0] &&
        p0_pin_out[0] == $past(general_timer_output_in)) // RULE4
        else $error("selected timer output not driven");
    a_rxd_follows_dir: assert property (disable iff (rst_in)
        alt_sel[1] |=> p0_pin_oe_out[1] == !$past(direction[1])) // RULE5
        else $error("uart receive pin ignores direction bit");
    a_gpio_direction: assert property (disable iff (rst_in)
        !alt_sel[4] |=> p0_pin_oe_out[4] == !$past(direction[4]) &&
        ext_irq1_n_out) // RULE6
        else $error("gpio pin direction or irq gating wrong");
    a_irq_input_only: assert property (disable iff (rst_in)
        alt_sel[3] ##1 alt_sel[3] |-> !p0_pin_oe_out[3] &&
        ext_irq0_n_out == $past(sif.synced[3])) // RULE7
        else $error("interrupt pin not an input");
    a_dir_reset_ones: assert property (rst_in |=> direction == p0pm_pkg::RST_DIR) // RULE10
        else $error("direction register reset value wrong");
    a_dir_readback: assert property (disable iff (rst_in)
        sfr_rd_in && sfr_addr_in == p0pm_pkg::ADDR_DIR |=>
        sfr_rdata_out == $past(direction)) // RULE11
        else $error("direction register read back wrong");
    a_drive_split: assert property (disable iff (rst_in)
        drive_en == 8'hFF ##1 drive_en == 8'hFF |->
        p0_hi_source_out == (p0_pin_oe_out & 8'hAA) &&
        p0_hi_sink_out == (p0_pin_oe_out & 8'h55)) // RULE12 RULE14
        else $error("high drive not split odd source, even sink");
    a_p1_gpio_mode: assert property (disable iff (rst_in)
        serial_port_mode_in != p0pm_pkg::SPI_MASTER_MODE |=>
        !p1_pin_oe_out[2] && p1_pin_oe_out[0] == !$past(p1_direction_in[0])) // RULE15
        else $error("port 1 direction wrong outside master mode");
    a_data_read_output: assert property (disable iff (rst_in)
        sfr_rd_in && sfr_addr_in == p0pm_pkg::ADDR_DATA && p0_pin_oe_out[7] |=>
        sfr_rdata_out[7] == $past(data_latch[7])) // RULE16
        else $error("output pin read does not return the latch");

    c_alt_enable: cover property (wr_alt ##1 alt_sel != 8'h00);
    c_gpio_output: cover property (wr_dir ##2 p0_pin_oe_out != 8'h00);
    c_irq_low: cover property (alt_sel[3] && !ext_irq0_n_out);
endmodule : p0pm_port

// file: p0pm_board.sv
// board-side model of the eight port 0 pins
// assumes the board drives every pin that the block leaves released
`timescale 1ns/100ps
module p0pm_board (
    // block side of the pins
    input wire logic [7:0] oe_in,
    input wire logic [7:0] drive_in,
    // level the board puts on released pins
    input wire logic [7:0] board_in,
    // resolved wire levels
    output logic [7:0] wire_out
);
    // per-bit resolution: driven pins show the block, the rest the board
    always_comb begin
        wire_out = (drive_in & oe_in) | (board_in & ~oe_in);
    end
endmodule : p0pm_board

// file: tb_top.sv
// self-checking bench for the port 0 pin mux and direction block
// assumes the block answers sfr reads one cycle after the strobe
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, ext = 8'h96, pins, rdata;
    logic [7:0] pout, oe, src, snk;
    logic gt = 1'b1, rxdd = 1'b0, txd = 1'b1, pwm = 1'b1;
    logic rxd, i0, i1, t0, t1;
    // port 1 starts in serial-master mode, as after a real boot
    logic [1:0] mode = 2'h1;
    logic [3:0] p1dir = 4'h0, p1oe;
    int failures = 0, samples_checked = 0;
    always #50 clk = ~clk;
    p0pm_board board (.oe_in(oe), .drive_in(pout), .board_in(ext), .wire_out(pins));
    p0pm_port uut (.sys_clk_in(clk), .rst_in(rst), .sfr_addr_in(addr),
        .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
        .p0_pin_in(pins), .p0_pin_out(pout), .p0_pin_oe_out(oe),
        .p0_hi_source_out(src), .p0_hi_sink_out(snk),
        .general_timer_output_in(gt), .uart_rxd_drive_in(rxdd), .uart_txd_in(txd),
        .pwm_in(pwm), .uart_rxd_out(rxd), .ext_irq0_n_out(i0), .ext_irq1_n_out(i1),
        .timer0_input_out(t0), .timer1_input_out(t1), .serial_port_mode_in(mode),
        .p1_direction_in(p1dir), .p1_pin_oe_out(p1oe));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_n
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : sfr_write
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("rdata", rdata, exp);
    endtask : sfr_read
    task automatic reset_check();
        wait_n(4);
        check("oe", oe, 8'h00);
        check("pin_out", pout, 8'hFF);
        check("source", src, 8'h00);
        check("p1_oe", {4'h0, p1oe}, 8'h0B);
        sfr_read(p0pm_pkg::ADDR_DATA, 8'h96);
        sfr_read(p0pm_pkg::ADDR_DRIVE, 8'h00);
        sfr_read(p0pm_pkg::ADDR_DIR, 8'hFF);
        sfr_read(p0pm_pkg::ADDR_ALT, 8'h00);
        sfr_read(8'h81, 8'h00);
    endtask : reset_check
    task automatic gpio_check();
        @(posedge clk);
        ext <= 8'h3C;
        sfr_write(p0pm_pkg::ADDR_DATA, 8'h5A);
        sfr_write(p0pm_pkg::ADDR_DIR, 8'h0F);
        wait_n(4);
        check("oe", oe, 8'hF0);
        check("pin_out", pout, 8'h5A);
        sfr_read(p0pm_pkg::ADDR_DATA, 8'h5C);
    endtask : gpio_check
    task automatic alt_check();
        sfr_write(p0pm_pkg::ADDR_DIR, 8'hFF);
        sfr_write(p0pm_pkg::ADDR_ALT, 8'hFF);
        wait_n(2);
        check("oe", oe, 8'h85);
        sfr_write(p0pm_pkg::ADDR_DIR, 8'h00);
        wait_n(2);
        check("oe", oe, 8'h87);
        check("pin_out", pout, 8'hDD);
    endtask : alt_check
    task automatic drive_check();
        sfr_write(p0pm_pkg::ADDR_ALT, 8'h00);
        sfr_write(p0pm_pkg::ADDR_DRIVE, 8'hFF);
        wait_n(2);
        check("source", src, 8'hAA);
        check("sink", snk, 8'h55);
        sfr_write(p0pm_pkg::ADDR_DIR, 8'hF0);
        wait_n(2);
        check("source", src, 8'h0A);
        check("sink", snk, 8'h05);
        sfr_read(p0pm_pkg::ADDR_DRIVE, 8'hFF);
    endtask : drive_check
    task automatic input_check();
        @(posedge clk);
        ext <= 8'hFF;
        sfr_write(p0pm_pkg::ADDR_DIR, 8'hFF);
        sfr_write(p0pm_pkg::ADDR_ALT, 8'h7A);
        wait_n(12);
        check("oe", oe, 8'h00);
        check("inputs", {3'h0, rxd, i0, i1, t0, t1}, 8'h1F);
        @(posedge clk);
        ext <= 8'h00;
        wait_n(12);
        check("inputs", {3'h0, rxd, i0, i1, t0, t1}, 8'h00);
        sfr_write(p0pm_pkg::ADDR_ALT, 8'h00);
        wait_n(3);
        check("inputs", {3'h0, rxd, i0, i1, t0, t1}, 8'h1C);
    endtask : input_check
    task automatic p1_check();
        @(posedge clk);
        p1dir <= 4'h0;
        mode <= 2'h0;
        wait_n(2);
        check("p1_oe", {4'h0, p1oe}, 8'h0B);
        @(posedge clk);
        p1dir <= 4'hF;
        wait_n(2);
        check("p1_oe", {4'h0, p1oe}, 8'h00);
        @(posedge clk);
        mode <= 2'h1;
        wait_n(2);
        check("p1_oe", {4'h0, p1oe}, 8'h0B);
    endtask : p1_check
    task automatic finish_test();
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        // both synchroniser flops reset to constants, so two edges in reset suffice
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("oe_in_reset", oe, 8'h00);
        check("p1_oe_in_reset", {4'h0, p1oe}, 8'h0B);
        reset_check();
        gpio_check();
        alt_check();
        drive_check();
        input_check();
        p1_check();
        finish_test();
    end
    initial begin
        #200000;
        failures++;
        finish_test();
    end
endmodule : tb_top
